// File: btiu_defs.svh
/*
 * constants of the basic trap and interrupt unit: register offsets,
 * field positions, reset values, cause codes and vector entries.
 * assumes inclusion by bare name from package and modules alike.
 */
`ifndef BTIU_DEFS_SVH
`define BTIU_DEFS_SVH

// ==========================================================
// register offsets on the plain register port (word index)
`define BTIU_OFS_MSTATUS 4'h0
`define BTIU_OFS_MIE 4'h1
`define BTIU_OFS_MIP 4'h2
`define BTIU_OFS_MTVEC 4'h3
`define BTIU_OFS_MEPC 4'h4
`define BTIU_OFS_MCAUSE 4'h5
`define BTIU_OFS_CTRL 4'h6

// ==========================================================
// field positions
`define BTIU_MSTATUS_MIE 3
`define BTIU_MSTATUS_MPIE 7
`define BTIU_MTVEC_BASE_LSB 7
`define BTIU_CTRL_DEBUG 0

// ==========================================================
// reset values
`define BTIU_RST_MSTATUS 32'h0000_0000
`define BTIU_RST_MIE 32'h0000_0000
`define BTIU_RST_MTVEC 32'h0000_0000
`define BTIU_RST_MEPC 32'h0000_0000
`define BTIU_RST_MCAUSE 32'h0000_0000

// ==========================================================
// cause codes, request lines and vector entries
`define BTIU_IRQ_MASK 32'hFFFF_0888
`define BTIU_CODE_SW 11'h003
`define BTIU_CODE_TIMER 11'h007
`define BTIU_CODE_EXT 11'h00B
`define BTIU_CODE_NMI_LDERR 11'h400
`define BTIU_CODE_NMI_STERR 11'h401
`define BTIU_CODE_NMI_LDPAR 11'h402
`define BTIU_CODE_NMI_STPAR 11'h403
`define BTIU_CODE_ILLEGAL 11'h002
`define BTIU_NMI_ENTRY 5'hF
`define BTIU_CSR_TIME 12'hC01
`define BTIU_CSR_TIMEH 12'hC81

`endif

// File: btiu_pkg.sv
/*
 * types of the basic trap and interrupt unit.
 * assumes btiu_defs.svh on the include path.
 */
`include "btiu_defs.svh"
package btiu_pkg;
	// ==========================================================
	// trap request travelling from the resolver to the csr update
	typedef struct packed {
		logic valid; // a trap is taken this cycle
		logic intr; // interrupt flag of the cause
		logic nmi; // non-maskable
		logic [10:0] code; // exception code
	} btiu_trap_t;

	// sequencer of the pending non-maskable fault
	typedef enum logic [1:0] {
		BTIU_NMI_IDLE = 2'b01,
		BTIU_NMI_PEND = 2'b10
	} btiu_nmi_state_t;
endpackage

// File: btiu_prio.sv
/*
 * fixed priority resolver of the maskable request lines.
 * assumes enabled requests already gated with global and local enables.
 */
`include "btiu_defs.svh"
module btiu_prio
	import btiu_pkg::*;
(
	input wire logic [31:0] i_req,
	output logic o_any,
	output logic [10:0] o_code
);
	// ==========================================================
	// custom lines first, highest number wins, then ext, sw, timer
	always_comb
	begin
		o_any = |i_req;
		o_code = 11'h000;
		if (i_req[7])
		begin
			o_code = `BTIU_CODE_TIMER; // timer is lowest
		end
		if (i_req[3])
		begin
			o_code = `BTIU_CODE_SW;
		end
		if (i_req[11])
		begin
			o_code = `BTIU_CODE_EXT;
		end
		for (int i = 16; i < 32; i++)
		begin
			if (i_req[i])
			begin
				o_code = 11'(i); // later index overrides earlier
			end
		end
	end
endmodule

// File: btiu_top.sv
/*
 * basic trap and interrupt unit of a 32-bit core: enables, pending
 * levels, priority, cause encoding, vector targets, entry and return.
 * assumes request lines and fault strobes synchronous to I_CLK_SYS
 * except I_IRQ, which is a pin and is synchronised here.
 */
// Strobed register access and the address map were left to the implementer.
`include "btiu_defs.svh"
module btiu_top
	import btiu_pkg::*;
#(
	parameter int LOCAL_CONTROLLER_SELECT_PARAM = 0
)
(
	input wire logic I_CLK_SYS,
	input wire logic I_RST_B,
	// register port
	input wire logic [3:0] i_ADDR,
	input wire logic [31:0] i_WDATA,
	input wire logic i_WR,
	input wire logic i_RD,
	output logic [31:0] o_RDATA,
	// request lines and local controller inputs
	input wire logic [31:0] i_IRQ,
	input wire logic i_CLIC_IRQ,
	// core side
	input wire logic [31:0] i_PC,
	input wire logic i_MRET,
	input wire logic i_EXC,
	input wire logic [10:0] i_EXC_CODE,
	input wire logic i_CSR_ACC,
	input wire logic [11:0] i_CSR_ADDR,
	input wire logic i_LD_ERR,
	input wire logic i_ST_ERR,
	input wire logic i_LD_PAR,
	input wire logic i_ST_PAR,
	output logic o_REDIRECT,
	output logic [31:0] o_TARGET,
	output logic o_ILLEGAL,
	output logic o_NMI_PEND
);
	// ==========================================================
	// elaboration check: only the basic architecture is built
	if (LOCAL_CONTROLLER_SELECT_PARAM != 0)
	begin : g_bad_sel
		$error("only the basic interrupt architecture is supported");
	end

	// ==========================================================
	// declarations
	logic [31:0] irq_s1_r; // first synchroniser stage
	logic [31:0] irq_s2_r; // synchronised lines
	logic [31:0] mip; // pending view
	logic mie_g_r, mie_g_nxt; // mstatus global enable
	logic mpie_r, mpie_nxt; // mstatus previous enable
	logic [31:0] mie_r, mie_nxt; // per line enables
	logic [24:0] tvec_base_r, tvec_base_nxt; // mtvec bits 31:7
	logic tvec_mode_r, tvec_mode_nxt; // 0 direct, 1 vectored
	logic [31:0] mepc_r, mepc_nxt;
	logic [31:0] mcause_r, mcause_nxt;
	logic debug_r, debug_nxt; // core in debug mode
	logic [31:0] rdata_r, rdata_nxt;
	btiu_nmi_state_t nmi_st_r, nmi_st_nxt;
	logic [10:0] nmi_code_r, nmi_code_nxt; // latched fault code
	logic fault_any; // any fault strobe this cycle
	logic [10:0] fault_code; // code of the winning fault
	logic [31:0] en_req; // enabled maskable requests
	logic irq_any;
	logic [10:0] irq_code;
	logic time_acc; // access to an absent time counter
	btiu_trap_t trap;
	logic [31:0] target;

	// ==========================================================
	// pin synchroniser; reserved lines are masked off so a stray
	// drive on them can never reach the resolver
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			irq_s1_r <= 32'h0000_0000;
			irq_s2_r <= 32'h0000_0000;
		end
		else
		begin
			irq_s1_r <= i_IRQ;
			irq_s2_r <= irq_s1_r;
		end
	end

	// mip is a pure level view, no latching, no writable state
	assign mip = irq_s2_r & `BTIU_IRQ_MASK;

	// enabled requests: global and line enable, never in debug
	assign en_req = (mie_g_r && !debug_r) ? (mip & mie_r) : 32'h0;

	// ==========================================================
	// fixed priority among the maskable lines
	btiu_prio u_prio (
		.i_req(en_req),
		.o_any(irq_any),
		.o_code(irq_code)
	);

	// time counters are absent; any access is illegal
	assign time_acc = i_CSR_ACC && (i_CSR_ADDR == `BTIU_CSR_TIME ||
		i_CSR_ADDR == `BTIU_CSR_TIMEH);

	// ==========================================================
	// trap selection: nmi over exceptions, exceptions over maskable.
	// the local controller input is not used in basic mode.
	always_comb
	begin
		trap = '0;
		if (nmi_st_r == BTIU_NMI_PEND && !debug_r)
		begin
			trap.valid = 1'b1;
			trap.intr = 1'b1;
			trap.nmi = 1'b1;
			trap.code = nmi_code_r;
		end
		else if (i_EXC || time_acc)
		begin
			trap.valid = 1'b1;
			trap.code = time_acc ? `BTIU_CODE_ILLEGAL : i_EXC_CODE;
		end
		else if (irq_any)
		begin
			trap.valid = 1'b1;
			trap.intr = 1'b1;
			trap.code = irq_code;
		end
	end

	// ==========================================================
	// fetch target of the selected trap or return
	always_comb
	begin
		if (trap.nmi)
		begin
			target = {tvec_base_r, `BTIU_NMI_ENTRY, 2'b00};
		end
		else if (trap.intr && tvec_mode_r)
		begin
			target = {tvec_base_r, 7'h00} +
				{19'h00000, trap.code, 2'b00};
		end
		else if (trap.valid)
		begin
			target = {tvec_base_r, 7'h00};
		end
		else
		begin
			target = mepc_r;
		end
	end

	assign o_REDIRECT = trap.valid || i_MRET;
	assign o_TARGET = target;
	assign o_ILLEGAL = time_acc;
	assign o_NMI_PEND = (nmi_st_r == BTIU_NMI_PEND);

	// ==========================================================
	// priority among simultaneous fault strobes
	always_comb
	begin
		fault_any = i_ST_PAR || i_LD_PAR || i_ST_ERR || i_LD_ERR;
		if (i_ST_PAR)
		begin
			fault_code = `BTIU_CODE_NMI_STPAR;
		end
		else if (i_LD_PAR)
		begin
			fault_code = `BTIU_CODE_NMI_LDPAR;
		end
		else if (i_ST_ERR)
		begin
			fault_code = `BTIU_CODE_NMI_STERR;
		end
		else
		begin
			fault_code = `BTIU_CODE_NMI_LDERR;
		end
	end

	// nmi latch: first fault held until the handler is entered;
	// faults while pending, except in the entry cycle, are dropped so mcause names the first
	always_comb
	begin
		nmi_st_nxt = nmi_st_r;
		nmi_code_nxt = nmi_code_r;
		unique case (nmi_st_r)
			BTIU_NMI_IDLE:
			begin
				if (fault_any)
				begin
					nmi_st_nxt = BTIU_NMI_PEND;
					nmi_code_nxt = fault_code;
				end
			end
			BTIU_NMI_PEND:
			begin
				// later faults discarded; leave once taken, but a
				// fault in the entry cycle itself is kept (set wins)
				if (trap.nmi)
				begin
					nmi_st_nxt = BTIU_NMI_IDLE;
					if (fault_any)
					begin
						nmi_st_nxt = BTIU_NMI_PEND;
						nmi_code_nxt = fault_code;
					end
				end
			end
			default:
			begin
				nmi_st_nxt = BTIU_NMI_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			nmi_st_r <= BTIU_NMI_IDLE;
			nmi_code_r <= 11'h000;
		end
		else
		begin
			nmi_st_r <= nmi_st_nxt;
			nmi_code_r <= nmi_code_nxt;
		end
	end

	// ==========================================================
	// csr state: software writes first, hardware trap effects win
	always_comb
	begin
		mie_g_nxt = mie_g_r;
		mpie_nxt = mpie_r;
		mie_nxt = mie_r;
		tvec_base_nxt = tvec_base_r;
		tvec_mode_nxt = tvec_mode_r;
		mepc_nxt = mepc_r;
		mcause_nxt = mcause_r;
		debug_nxt = debug_r;
		if (i_WR)
		begin
			unique case (i_ADDR)
				`BTIU_OFS_MSTATUS:
				begin
					mie_g_nxt = i_WDATA[`BTIU_MSTATUS_MIE];
					mpie_nxt = i_WDATA[`BTIU_MSTATUS_MPIE];
				end
				`BTIU_OFS_MIE: mie_nxt = i_WDATA & `BTIU_IRQ_MASK;
				`BTIU_OFS_MTVEC:
				begin
					// bits 6:1 stay fixed, bit 0 is the mode; keeps 128 byte alignment
					tvec_base_nxt = i_WDATA[31:`BTIU_MTVEC_BASE_LSB];
					tvec_mode_nxt = i_WDATA[0];
				end
				`BTIU_OFS_MEPC: mepc_nxt = {i_WDATA[31:1], 1'b0};
				`BTIU_OFS_MCAUSE: mcause_nxt = i_WDATA;
				`BTIU_OFS_CTRL: debug_nxt = i_WDATA[`BTIU_CTRL_DEBUG];
				default:
				begin
					// unmapped or read-only: ignored
				end
			endcase
		end
		if (trap.valid)
		begin
			mepc_nxt = i_PC;
			mpie_nxt = mie_g_r;
			mie_g_nxt = 1'b0;
			mcause_nxt = {trap.intr, 20'h00000, trap.code};
		end
		else if (i_MRET)
		begin
			mie_g_nxt = mpie_r;
			mpie_nxt = 1'b1;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			mie_g_r <= 1'b0;
			mpie_r <= 1'b0;
			mie_r <= `BTIU_RST_MIE;
			tvec_base_r <= 25'h0000000;
			tvec_mode_r <= 1'b0;
			mepc_r <= `BTIU_RST_MEPC;
			mcause_r <= `BTIU_RST_MCAUSE;
			debug_r <= 1'b0;
		end
		else
		begin
			mie_g_r <= mie_g_nxt;
			mpie_r <= mpie_nxt;
			mie_r <= mie_nxt;
			tvec_base_r <= tvec_base_nxt;
			tvec_mode_r <= tvec_mode_nxt;
			mepc_r <= mepc_nxt;
			mcause_r <= mcause_nxt;
			debug_r <= debug_nxt;
		end
	end

	// ==========================================================
	// read data, valid in the cycle after the read strobe
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (i_RD)
		begin
			unique case (i_ADDR)
				`BTIU_OFS_MSTATUS:
				begin
					rdata_nxt[`BTIU_MSTATUS_MIE] = mie_g_r;
					rdata_nxt[`BTIU_MSTATUS_MPIE] = mpie_r;
				end
				`BTIU_OFS_MIE: rdata_nxt = mie_r;
				`BTIU_OFS_MIP: rdata_nxt = mip;
				`BTIU_OFS_MTVEC: rdata_nxt = {tvec_base_r, 6'h00, tvec_mode_r};
				`BTIU_OFS_MEPC: rdata_nxt = mepc_r;
				`BTIU_OFS_MCAUSE: rdata_nxt = mcause_r;
				`BTIU_OFS_CTRL: rdata_nxt = {31'h0, debug_r};
				default: rdata_nxt = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end
	assign o_RDATA = rdata_r;

	// ==========================================================
	// checks
	property p_no_irq_debug;
		@(posedge I_CLK_SYS) disable iff (!I_RST_B)
		debug_r |-> !(trap.valid && trap.intr);
	endproperty
	a_no_irq_debug: assert property (p_no_irq_debug)
		else $error("interrupt taken in debug mode");

	property p_entry_save;
		@(posedge I_CLK_SYS) disable iff (!I_RST_B)
		trap.valid |=> (mepc_r == $past(i_PC)) && (mpie_r == $past(mie_g_r));
	endproperty
	a_entry_save: assert property (p_entry_save)
		else $error("entry did not save pc and enable");

	property p_entry_clear;
		@(posedge I_CLK_SYS) disable iff (!I_RST_B)
		trap.valid |=> !mie_g_r;
	endproperty
	a_entry_clear: assert property (p_entry_clear)
		else $error("global enable not cleared on entry");

	property p_mret;
		@(posedge I_CLK_SYS) disable iff (!I_RST_B)
		(i_MRET && !trap.valid) |-> (o_TARGET == mepc_r) ##1
			(mie_g_r == $past(mpie_r));
	endproperty
	a_mret: assert property (p_mret)
		else $error("return target or enable restore wrong");

	property p_nmi_vec;
		@(posedge I_CLK_SYS) disable iff (!I_RST_B)
		trap.nmi |-> o_TARGET == {tvec_base_r, 7'h3C};
	endproperty
	a_nmi_vec: assert property (p_nmi_vec)
		else $error("nmi target not entry fifteen");

	property p_exc_base;
		@(posedge I_CLK_SYS) disable iff (!I_RST_B)
		(trap.valid && !trap.intr) |-> o_TARGET[6:0] == 7'h00;
	endproperty
	a_exc_base: assert property (p_exc_base)
		else $error("exception target not table base");

	property p_gate;
		@(posedge I_CLK_SYS) disable iff (!I_RST_B)
		(trap.valid && trap.intr && !trap.nmi) |->
			mie_g_r && mie_r[trap.code[4:0]];
	endproperty
	a_gate: assert property (p_gate)
		else $error("interrupt taken while disabled");

	property p_first_fault;
		@(posedge I_CLK_SYS) disable iff (!I_RST_B)
		(o_NMI_PEND && !trap.nmi) |=> $stable(nmi_code_r);
	endproperty
	a_first_fault: assert property (p_first_fault)
		else $error("latched fault code overwritten");

	property p_time_illegal;
		@(posedge I_CLK_SYS) disable iff (!I_RST_B)
		(time_acc && nmi_st_r == BTIU_NMI_IDLE) |=>
			mcause_r == {21'h0, `BTIU_CODE_ILLEGAL};
	endproperty
	a_time_illegal: assert property (p_time_illegal)
		else $error("time access not illegal");
endmodule

// File: btiu_src.sv
/*
 * model of the interrupt sources that sit beside the trap unit.
 * assumes one clock and an active-low asynchronous reset.
 */
`include "btiu_defs.svh"
module btiu_src
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [31:0] i_raise, // source events, one bit a line
	input wire logic [31:0] i_done, // completion sent by the handler
	output logic [31:0] o_irq // level request lines
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// request levels
	// a line stays up until the handler reports completion, since the
	// unit has no acknowledge; reserved lines never leave zero
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_irq <= 32'h0000_0000;
		else
			o_irq <= (o_irq | i_raise) & ~i_done & `BTIU_IRQ_MASK;
	end
endmodule

// File: btiu_top_tb.sv
/*
 * self-checking bench of the trap unit with a source model.
 * assumes the register offsets and codes of btiu_defs.svh.
 */
`include "btiu_defs.svh"
module btiu_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] BASE = 32'h0000_1000; // 128-byte aligned
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	logic clk, rst_b, wr_s, rd_s, clic, mret, exc, csr_acc;
	logic redir_s, illegal, nmi_pend;
	logic [3:0] addr, flt;
	logic [10:0] exc_code;
	logic [11:0] csr_addr;
	logic [31:0] wdata, rdata, irq, pc, target, raise, done;

	// ==========================================================
	// instances
	btiu_top #(.LOCAL_CONTROLLER_SELECT_PARAM(0)) dut (
		.I_CLK_SYS(clk), .I_RST_B(rst_b), .i_ADDR(addr), .i_WDATA(wdata),
		.i_WR(wr_s), .i_RD(rd_s), .o_RDATA(rdata), .i_IRQ(irq),
		.i_CLIC_IRQ(clic), .i_PC(pc), .i_MRET(mret), .i_EXC(exc),
		.i_EXC_CODE(exc_code), .i_CSR_ACC(csr_acc), .i_CSR_ADDR(csr_addr),
		.i_LD_ERR(flt[0]), .i_ST_ERR(flt[1]), .i_LD_PAR(flt[2]),
		.i_ST_PAR(flt[3]), .o_REDIRECT(redir_s), .o_TARGET(target),
		.o_ILLEGAL(illegal), .o_NMI_PEND(nmi_pend));
	btiu_src u_src (.i_clk(clk), .i_rst_b(rst_b), .i_raise(raise),
		.i_done(done), .o_irq(irq));

	// ==========================================================
	// clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			summarize();
		end
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	// waits a bounded time for a redirect, then checks its target
	task automatic redir(input logic [31:0] exp);
		int i;
		#1;
		for (i = 0; i < 8 && redir_s !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk({31'h0, redir_s}, 32'h1);
		chk(target, exp);
	endtask
	task automatic quiet;
		repeat (4)
		begin
			@(posedge clk);
			#1 chk({31'h0, redir_s}, 32'h0);
		end
	endtask
	// one-cycle source event, then time for the two-flop sync
	task automatic line_ev(input logic [31:0] up, input logic [31:0] dn);
		@(posedge clk);
		raise <= up;
		done <= dn;
		@(posedge clk);
		raise <= 32'h0;
		done <= 32'h0;
		repeat (4) @(posedge clk);
	endtask
	task automatic fault(input logic [3:0] f);
		@(posedge clk);
		flt <= f;
		@(posedge clk);
		flt <= 4'h0;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset;
		rd(`BTIU_OFS_MSTATUS, `BTIU_RST_MSTATUS);
		rd(`BTIU_OFS_MIE, `BTIU_RST_MIE);
		rd(`BTIU_OFS_MCAUSE, `BTIU_RST_MCAUSE);
		line_ev(32'h0000_0800, 32'h0);
		quiet();
		line_ev(32'h0, 32'h0000_0800);
		wr(`BTIU_OFS_MTVEC, 32'hFFFF_FFFF);
		rd(`BTIU_OFS_MTVEC, 32'hFFFF_FF81);
		wr(`BTIU_OFS_MTVEC, BASE | 32'h1);
		wr(4'hF, 32'h1234_5678);
		rd(4'hF, 32'h0);
	endtask
	task automatic t_exc;
		wr(`BTIU_OFS_MSTATUS, 32'h8);
		@(posedge clk);
		pc <= 32'h0000_2000;
		exc <= 1'b1;
		exc_code <= 11'h005;
		redir(BASE);
		@(posedge clk);
		exc <= 1'b0;
		rd(`BTIU_OFS_MEPC, 32'h0000_2000);
		rd(`BTIU_OFS_MCAUSE, 32'h0000_0005);
		rd(`BTIU_OFS_MSTATUS, 32'h80);
	endtask
	task automatic t_time;
		int k;
		for (k = 0; k < 3; k++)
		begin
			@(posedge clk);
			csr_acc <= 1'b1;
			csr_addr <= k == 0 ? `BTIU_CSR_TIME :
				(k == 1 ? `BTIU_CSR_TIMEH : 12'hC00);
			#1 chk({31'h0, illegal}, k < 2 ? 32'h1 : 32'h0);
			if (k < 2)
				redir(BASE);
			@(posedge clk);
			csr_acc <= 1'b0;
		end
		rd(`BTIU_OFS_MCAUSE, 32'h0000_0002);
	endtask
	task automatic t_irq;
		int ord [5];
		int k;
		ord = '{31, 16, 11, 3, 7};
		line_ev(32'h8001_0888, 32'h0);
		rd(`BTIU_OFS_MIP, 32'h8001_0888);
		wr(`BTIU_OFS_MIP, 32'h0);
		rd(`BTIU_OFS_MIP, 32'h8001_0888);
		wr(`BTIU_OFS_MIE, `BTIU_IRQ_MASK);
		quiet();
		wr(`BTIU_OFS_MIE, 32'h0);
		wr(`BTIU_OFS_MSTATUS, 32'h8);
		quiet();
		wr(`BTIU_OFS_CTRL, 32'h1);
		wr(`BTIU_OFS_MIE, `BTIU_IRQ_MASK);
		quiet();
		wr(`BTIU_OFS_MSTATUS, 32'h0);
		wr(`BTIU_OFS_CTRL, 32'h0);
		for (k = 0; k < 5; k++)
		begin
			wr(`BTIU_OFS_MSTATUS, 32'h8);
			redir(BASE + 32'(4 * ord[k]));
			rd(`BTIU_OFS_MCAUSE, 32'h8000_0000 | 32'(ord[k]));
			rd(`BTIU_OFS_MSTATUS, 32'h80);
			line_ev(32'h0, 32'h1 << ord[k]);
		end
		wr(`BTIU_OFS_MIE, 32'h0);
	endtask
	task automatic t_ret;
		wr(`BTIU_OFS_MTVEC, BASE);
		wr(`BTIU_OFS_MIE, 32'h0000_0800);
		line_ev(32'h0000_0800, 32'h0);
		wr(`BTIU_OFS_MSTATUS, 32'h8);
		redir(BASE);
		line_ev(32'h0, 32'h0000_0800);
		wr(`BTIU_OFS_MEPC, 32'h0000_2468);
		@(posedge clk);
		mret <= 1'b1;
		redir(32'h0000_2468);
		@(posedge clk);
		mret <= 1'b0;
		rd(`BTIU_OFS_MSTATUS, 32'h88);
		wr(`BTIU_OFS_MSTATUS, 32'h0);
		wr(`BTIU_OFS_MIE, 32'h0);
		wr(`BTIU_OFS_MTVEC, BASE | 32'h1);
	endtask
	task automatic t_nmi;
		int k;
		for (k = 0; k < 4; k++)
		begin
			fault(4'(1 << k));
			redir(BASE | 32'h3C);
			chk({31'h0, nmi_pend}, 32'h1);
			rd(`BTIU_OFS_MCAUSE, 32'h8000_0400 + 32'(k));
		end
		fault(4'hF);
		redir(BASE | 32'h3C);
		rd(`BTIU_OFS_MCAUSE, 32'h8000_0403);
		wr(`BTIU_OFS_CTRL, 32'h1);
		fault(4'h1);
		fault(4'h8);
		quiet();
		chk({31'h0, nmi_pend}, 32'h1);
		wr(`BTIU_OFS_CTRL, 32'h0);
		redir(BASE | 32'h3C);
		rd(`BTIU_OFS_MCAUSE, 32'h8000_0400);
	endtask

	// ==========================================================
	// verdict and main sequence
	task automatic summarize;
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		{rst_b, wr_s, rd_s, mret, exc, csr_acc} = 6'h00;
		clic = 1'b1; // ignored in basic mode
		{addr, flt} = 8'h00;
		{exc_code, csr_addr} = 23'h0;
		{wdata, pc, raise, done} = 128'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_exc();
		t_time();
		t_irq();
		t_ret();
		t_nmi();
		summarize();
	end
endmodule
